// >>> design/adr_readout.sv
// result and status readout of a three-axis accelerometer
// assumes a register read port, samples synchronous to clk, one clock
`timescale 1ns/1ps
`include "adr_params.svh"

module adr_readout #(
    parameter int SAMPLE_W = `ADR_SAMPLE_W,
    parameter int COUNT_W  = `ADR_COUNT_W
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // measurement side
    input  wire logic                 smp_valid,
    input  wire adr_pkg::adr_sample_t smp_x,
    input  wire adr_pkg::adr_sample_t smp_y,
    input  wire adr_pkg::adr_sample_t smp_z,
    input  wire logic                 second_motion_flag,
    input  wire logic                 motion_flag,
    input  wire logic                 stillness_flag,
    input  wire adr_pkg::adr_count_t  fifo_level,
    // register read port
    input  wire logic                 rd_en,
    input  wire logic [7:0]           rd_addr,
    output logic [7:0]                rd_data_q,
    output logic                      rd_valid_q
);
    import adr_pkg::*;

    // ****************************************
    // elaboration checks
    // ****************************************
    if (SAMPLE_W != `ADR_SAMPLE_W) begin : g_chk_sample
        $error("sample width must be 12");
    end
    if (COUNT_W != `ADR_COUNT_W) begin : g_chk_count
        $error("count width must be 10");
    end

    adr_top_st_t q;
    adr_top_st_t d;
    adr_sample_t pk_w [`ADR_AXES];

    // ****************************************
    // address decode
    // ****************************************
    function automatic logic pk_hit_h(input logic [7:0] a, input int ax);
        pk_hit_h = (a == 8'(`ADR_OFF_XPK_H + 2 * ax));
    endfunction

    function automatic logic pk_hit_l(input logic [7:0] a, input int ax);
        pk_hit_l = (a == 8'(`ADR_OFF_XPK_H + 2 * ax + 1));
    endfunction

    function automatic logic [7:0] low_byte(input logic [3:0] nib);
        low_byte = {nib, 4'h0};
    endfunction

    // ****************************************
    // peak trackers
    // ****************************************
    genvar ax;
    for (ax = 0; ax < `ADR_AXES; ax++) begin : g_axis
        adr_peak_if u_if ();
        assign u_if.sample_valid = smp_valid;
        assign u_if.sample       = (ax == 0) ? smp_x : ((ax == 1) ? smp_y : smp_z);
        assign u_if.restart      = rd_en && (pk_hit_h(rd_addr, ax) || pk_hit_l(rd_addr, ax));
        assign pk_w[ax]          = u_if.peak;

        adr_peak u_peak (
            .clk  (clk),
            .nrst (nrst),
            .pk   (u_if.tracker)
        );

        property p_peak_high_map;
            @(posedge clk) disable iff (!nrst)
            rd_en && pk_hit_h(rd_addr, ax) |=> rd_data_q == $past(pk_w[ax][11:4]);
        endproperty
        a_peak_high_map: assert property (p_peak_high_map) else $error("peak high wrong");

        property p_peak_low_map;
            @(posedge clk) disable iff (!nrst)
            rd_en && pk_hit_l(rd_addr, ax)
            |=> rd_data_q[3:0] == 4'h0
                && rd_data_q[7:4] == ($past(q.pk_armed[ax]) ? $past(q.pk_low_hold[ax])
                                                             : $past(pk_w[ax][3:0]));
        endproperty
        a_peak_low_map: assert property (p_peak_low_map) else $error("peak low wrong");

        property p_pair_snapshot;
            @(posedge clk) disable iff (!nrst)
            rd_en && pk_hit_h(rd_addr, ax) ##1 rd_en && pk_hit_l(rd_addr, ax)
            |=> rd_data_q[7:4] == $past(pk_w[ax][3:0], 2);
        endproperty
        a_pair_snapshot: assert property (p_pair_snapshot) else $error("pair split");
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d          = q;
        d.rd_valid = rd_en;
        d.flags    = {second_motion_flag, motion_flag, stillness_flag};
        d.count    = (fifo_level > `ADR_COUNT_MAX) ? `ADR_COUNT_MAX : fifo_level;
        if (smp_valid) begin
            d.res[0] = smp_x;
            d.res[1] = smp_y;
            d.res[2] = smp_z;
        end
        if (rd_en) begin
            case (rd_addr)
                `ADR_OFF_ACT: begin
                    d.rd_data = {1'b0, q.flags, 4'h0};
                end
                `ADR_OFF_CNT_H: begin
                    d.rd_data = {6'h00, q.count[9:8]};
                end
                `ADR_OFF_CNT_L: begin
                    d.rd_data = q.count[7:0];
                end
                `ADR_OFF_X_H: begin
                    d.rd_data = q.res[0][11:4];
                end
                `ADR_OFF_X_L: begin
                    d.rd_data = low_byte(q.res[0][3:0]);
                end
                `ADR_OFF_Y_H: begin
                    d.rd_data    = q.res[1][11:4];
                    d.y_low_hold = q.res[1][3:0];
                end
                `ADR_OFF_Y_L: begin
                    d.rd_data = low_byte(q.y_low_hold);
                end
                `ADR_OFF_Z_H: begin
                    d.rd_data = q.res[2][11:4];
                end
                `ADR_OFF_Z_L: begin
                    d.rd_data = low_byte(q.res[2][3:0]);
                end
                default: begin
                    d.rd_data = `ADR_RST_BYTE;
                end
            endcase
            for (int a = 0; a < `ADR_AXES; a++) begin
                if (pk_hit_h(rd_addr, a)) begin
                    d.rd_data        = pk_w[a][11:4];
                    d.pk_low_hold[a] = pk_w[a][3:0];
                    d.pk_armed[a]    = 1'b1;
                end
                if (pk_hit_l(rd_addr, a)) begin
                    d.rd_data     = low_byte(q.pk_armed[a] ? q.pk_low_hold[a] : pk_w[a][3:0]);
                    d.pk_armed[a] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rd_data_q  = q.rd_data;
    assign rd_valid_q = q.rd_valid;

    // ****************************************
    // checks
    // ****************************************
    property p_answer_next;
        @(posedge clk) disable iff (!nrst)
        rd_en |=> rd_valid_q ##1 (rd_valid_q == $past(rd_en));
    endproperty
    a_answer_next: assert property (p_answer_next) else $error("no answer after read");

    property p_flags_map;
        @(posedge clk) disable iff (!nrst)
        rd_en && rd_addr == `ADR_OFF_ACT
        |=> rd_data_q[7] == 1'b0 && rd_data_q[3:0] == 4'h0
            && rd_data_q[`ADR_BIT_SECOND] == $past(q.flags[2])
            && rd_data_q[`ADR_BIT_MOTION] == $past(q.flags[1])
            && rd_data_q[`ADR_BIT_STILL] == $past(q.flags[0]);
    endproperty
    a_flags_map: assert property (p_flags_map) else $error("activity flags wrong");

    property p_flag_follows;
        @(posedge clk) disable iff (!nrst)
        motion_flag ##1 (rd_en && rd_addr == `ADR_OFF_ACT) |=> rd_data_q[`ADR_BIT_MOTION];
    endproperty
    a_flag_follows: assert property (p_flag_follows) else $error("activity flag lost");

    property p_count_range;
        @(posedge clk) disable iff (!nrst)
        ##1 q.count <= `ADR_COUNT_MAX;
    endproperty
    a_count_range: assert property (p_count_range) else $error("count above 512");

    property p_count_full;
        @(posedge clk) disable iff (!nrst)
        fifo_level == `ADR_COUNT_MAX ##1 (rd_en && rd_addr == `ADR_OFF_CNT_H)
        |=> rd_data_q == 8'h02;
    endproperty
    a_count_full: assert property (p_count_full) else $error("full count wrong");

    property p_count_split;
        @(posedge clk) disable iff (!nrst)
        rd_en && (rd_addr == `ADR_OFF_CNT_H || rd_addr == `ADR_OFF_CNT_L)
        |=> rd_data_q == (($past(rd_addr) == `ADR_OFF_CNT_H) ? {6'h00, $past(q.count[9:8])}
                                                            : $past(q.count[7:0]));
    endproperty
    a_count_split: assert property (p_count_split) else $error("count split wrong");

    property p_result_high;
        @(posedge clk) disable iff (!nrst)
        smp_valid ##1 (rd_en && rd_addr == `ADR_OFF_X_H) |=> rd_data_q == $past(smp_x[11:4], 2);
    endproperty
    a_result_high: assert property (p_result_high) else $error("x high wrong");

    property p_result_low;
        @(posedge clk) disable iff (!nrst)
        rd_en && (rd_addr == `ADR_OFF_X_L || rd_addr == `ADR_OFF_Y_L || rd_addr == `ADR_OFF_Z_L)
        |=> rd_data_q[3:0] == 4'h0;
    endproperty
    a_result_low: assert property (p_result_low) else $error("low nibble not zero");

    property p_y_snapshot;
        @(posedge clk) disable iff (!nrst)
        (rd_en && rd_addr == `ADR_OFF_Y_H) ##1 (rd_en && rd_addr == `ADR_OFF_Y_L)
        |=> rd_data_q[7:4] == $past(q.res[1][3:0], 2);
    endproperty
    a_y_snapshot: assert property (p_y_snapshot) else $error("y low not latched");

    property p_unmapped;
        @(posedge clk) disable iff (!nrst)
        rd_en && rd_addr > `ADR_OFF_ZPK_L |=> rd_data_q == `ADR_RST_BYTE;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule // adr_readout

// >>> common/adr_params.svh
// constants of the accelerometer result readout block
// assumes nothing; included by the package and by the design files
`ifndef ADR_PARAMS_SVH
`define ADR_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define ADR_OFF_ACT      8'h05
`define ADR_OFF_CNT_H    8'h06
`define ADR_OFF_CNT_L    8'h07
`define ADR_OFF_X_H      8'h08
`define ADR_OFF_X_L      8'h09
`define ADR_OFF_Y_H      8'h0a
`define ADR_OFF_Y_L      8'h0b
`define ADR_OFF_Z_H      8'h0c
`define ADR_OFF_Z_L      8'h0d
`define ADR_OFF_XPK_H    8'h15
`define ADR_OFF_XPK_L    8'h16
`define ADR_OFF_YPK_H    8'h17
`define ADR_OFF_YPK_L    8'h18
`define ADR_OFF_ZPK_H    8'h19
`define ADR_OFF_ZPK_L    8'h1a

// ****************************************
// field layout and reset values
// ****************************************
`define ADR_BIT_SECOND   6
`define ADR_BIT_MOTION   5
`define ADR_BIT_STILL    4
`define ADR_SAMPLE_W     12
`define ADR_COUNT_W      10
`define ADR_COUNT_MAX    10'h200
`define ADR_AXES         3
`define ADR_RST_BYTE     8'h00

`endif

// >>> common/adr_pkg.sv
// types of the accelerometer result readout block
// assumes the constants header is on the include path
`include "adr_params.svh"

package adr_pkg;

    typedef logic signed [`ADR_SAMPLE_W-1:0] adr_sample_t;
    typedef logic [`ADR_COUNT_W-1:0]         adr_count_t;

    // ****************************************
    // peak tracker state
    // ****************************************
    typedef struct packed {
        adr_sample_t peak;
        logic        valid;
    } adr_peak_st_t;

    // ****************************************
    // readout state
    // ****************************************
    typedef struct packed {
        logic [7:0]                   rd_data;
        logic                         rd_valid;
        adr_sample_t [`ADR_AXES-1:0]  res;
        logic [3:0]                   y_low_hold;
        logic [2:0]                   flags;
        adr_count_t                   count;
        logic [`ADR_AXES-1:0][3:0]    pk_low_hold;
        logic [`ADR_AXES-1:0]         pk_armed;
    } adr_top_st_t;

endpackage

// >>> common/adr_peak_if.sv
// link between the readout and one per-axis peak tracker
// assumes the package is compiled first
`timescale 1ns/1ps

interface adr_peak_if;
    import adr_pkg::*;
    logic        sample_valid;
    adr_sample_t sample;
    logic        restart;
    adr_sample_t peak;

    modport tracker (input sample_valid, input sample, input restart, output peak);
    modport owner   (output sample_valid, output sample, output restart, input peak);
endinterface

// >>> design/adr_peak.sv
// per-axis highest magnitude tracker
// assumes one clock, synchronous active low reset
`timescale 1ns/1ps
`include "adr_params.svh"

module adr_peak (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // link to the readout
    adr_peak_if.tracker pk
);
    import adr_pkg::*;

    adr_peak_st_t q;
    adr_peak_st_t d;

    function automatic logic [`ADR_SAMPLE_W-1:0] mag(input adr_sample_t v);
        mag = v[`ADR_SAMPLE_W-1] ? (~v + 1'b1) : v;
    endfunction

    // ****************************************
    // tracking
    // ****************************************
    always_comb begin
        d = q;
        if (pk.restart) begin
            d.valid = 1'b0;
            d.peak  = '0;
        end
        if (pk.sample_valid && (!d.valid || (mag(pk.sample) > mag(d.peak)))) begin
            d.valid = 1'b1;
            d.peak  = pk.sample;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pk.peak = q.peak;

    // ****************************************
    // checks
    // ****************************************
    property p_restart_clears;
        @(posedge clk) disable iff (!nrst)
        pk.restart && !pk.sample_valid |=> q.peak == '0 && !q.valid;
    endproperty
    a_restart_clears: assert property (p_restart_clears) else $error("peak not restarted");

    property p_restart_then_load;
        @(posedge clk) disable iff (!nrst)
        pk.restart && pk.sample_valid |=> q.valid && q.peak == $past(pk.sample);
    endproperty
    a_restart_then_load: assert property (p_restart_then_load) else $error("first sample lost");

    property p_keep_larger;
        @(posedge clk) disable iff (!nrst)
        pk.sample_valid && !pk.restart && q.valid && (mag(pk.sample) <= mag(q.peak))
        |=> q.peak == $past(q.peak);
    endproperty
    a_keep_larger: assert property (p_keep_larger) else $error("peak overwritten");

    property p_take_larger;
        @(posedge clk) disable iff (!nrst)
        pk.sample_valid && !pk.restart && (mag(pk.sample) > mag(q.peak))
        |=> q.peak == $past(pk.sample);
    endproperty
    a_take_larger: assert property (p_take_larger) else $error("larger sample missed");

endmodule // adr_peak

// >>> testbench/adr_host.sv
// host model that reads the result registers over the register read port
// assumes one clock shared with the readout, inputs driven 1 ns after the rising edge
`timescale 1ns/1ps

module adr_host (
    // clock
    input  wire logic       clk,
    // register read port
    output logic            rd_en,
    output logic [7:0]      rd_addr,
    input  wire logic [7:0] rd_data_q,
    input  wire logic       rd_valid_q
);
    // ****************************************
    // idle state
    // ****************************************
    initial begin
        rd_en   = 1'b0;
        rd_addr = 8'hff;
    end

    // ****************************************
    // one read, or two reads back to back
    // ****************************************
    task automatic rd_burst(input logic [7:0] a0, input logic [7:0] a1, input bit two,
                            output logic [7:0] d0, output logic [7:0] d1);
        d1 = 8'hxx;
        @(posedge clk);
        #1;
        rd_en   = 1'b1;
        rd_addr = a0;
        @(posedge clk);
        #1;
        d0 = (rd_valid_q === 1'b1) ? rd_data_q : 8'hxx;
        if (two) begin
            rd_addr = a1;
            @(posedge clk);
            #1;
            d1 = (rd_valid_q === 1'b1) ? rd_data_q : 8'hxx;
        end
        rd_en   = 1'b0;
        rd_addr = ~rd_addr;
    endtask
endmodule // adr_host

// >>> testbench/testbench.sv
// self-checking testbench of the accelerometer result readout
// assumes the package, interface and design files are compiled first
`timescale 1ns/1ps

module testbench;
    import adr_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic        clk;
    logic        nrst;
    logic        smp_valid;
    adr_sample_t smp_x;
    adr_sample_t smp_y;
    adr_sample_t smp_z;
    logic        s2_flag;
    logic        mo_flag;
    logic        st_flag;
    adr_count_t  fifo_level;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic [7:0]  rd_data_q;
    logic        rd_valid_q;
    int          n_errors;
    int          checks;
    logic [7:0]  d0;
    logic [7:0]  d1;

    adr_readout i_adr_readout (.clk(clk), .nrst(nrst), .smp_valid(smp_valid), .smp_x(smp_x),
        .smp_y(smp_y), .smp_z(smp_z), .second_motion_flag(s2_flag), .motion_flag(mo_flag),
        .stillness_flag(st_flag), .fifo_level(fifo_level), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));
    adr_host i_adr_host (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_q(rd_data_q),
        .rd_valid_q(rd_valid_q));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic get(input logic [7:0] a);
        i_adr_host.rd_burst(a, a, 1'b0, d0, d1);
    endtask

    task automatic get2(input logic [7:0] a);
        i_adr_host.rd_burst(a, a + 8'h01, 1'b1, d0, d1);
    endtask

    task automatic push(input adr_sample_t x, input adr_sample_t y, input adr_sample_t z);
        @(posedge clk);
        #1;
        smp_valid = 1'b1;
        smp_x = x;
        smp_y = y;
        smp_z = z;
        @(posedge clk);
        #1;
        smp_valid = 1'b0;
    endtask

    task automatic final_report;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        logic [7:0] offs [17] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c,
            8'h0d, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h0e, 8'h42};
        foreach (offs[i]) begin
            get(offs[i]);
            chk(d0, 8'h00);
        end
    endtask

    task automatic t_flags;
        for (int i = 0; i < 8; i++) begin
            {s2_flag, mo_flag, st_flag} = i[2:0];
            get(8'h05);
            chk(d0, {1'b0, i[2:0], 4'h0});
        end
    endtask

    task automatic t_count;
        adr_count_t cnt [5] = '{10'h000, 10'h001, 10'h0a5, 10'h1ff, 10'h200};
        foreach (cnt[i]) begin
            fifo_level = cnt[i];
            get2(8'h06);
            chk(d0, {6'h00, cnt[i][9:8]});
            chk(d1, cnt[i][7:0]);
        end
        fifo_level = 10'h3ff;
        get2(8'h06);
        chk(d0, 8'h02);
        chk(d1, 8'h00);
    endtask

    task automatic t_result;
        adr_sample_t v [3] = '{12'h800, 12'h7ff, 12'h35a};
        push(v[0], v[1], v[2]);
        for (int a = 0; a < 3; a++) begin
            get2(8'h08 + 8'(2 * a));
            chk(d0, v[a][11:4]);
            chk(d1, {v[a][3:0], 4'h0});
        end
        get(8'h0a);
        push(12'h111, 12'h0c3, 12'h222);
        get(8'h0b);
        chk(d0, 8'hf0);
        get(8'h0a);
        chk(d0, 8'h0c);
    endtask

    task automatic t_peak;
        for (int a = 0; a < 3; a++) get2(8'h15 + 8'(2 * a));
        push(12'h013, 12'h013, 12'h013);
        push(12'hfa7, 12'hfa7, 12'hfa7);
        push(12'h045, 12'h045, 12'h045);
        push(12'h059, 12'h059, 12'h059);
        for (int a = 0; a < 3; a++) begin
            get2(8'h15 + 8'(2 * a));
            chk(d0, 8'hfa);
            chk(d1, 8'h70);
        end
        for (int a = 0; a < 3; a++) begin
            get2(8'h15 + 8'(2 * a));
            chk(d0, 8'h00);
            chk(d1, 8'h00);
        end
        push(12'h005, 12'hffb, 12'h005);
        for (int a = 0; a < 3; a++) begin
            get2(8'h15 + 8'(2 * a));
            chk(d0, (a == 1) ? 8'hff : 8'h00);
            chk(d1, (a == 1) ? 8'hb0 : 8'h50);
        end
        fork
            push(12'h6c1, 12'h6c1, 12'h6c1);
            get(8'h15);
        join
        chk(d0, 8'h00);
        get2(8'h15);
        chk(d0, 8'h6c);
        chk(d1, 8'h10);
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        n_errors = 0;
        checks = 0;
        nrst = 1'b0;
        smp_valid = 1'b0;
        smp_x = '0;
        smp_y = '0;
        smp_z = '0;
        {s2_flag, mo_flag, st_flag} = 3'h0;
        fifo_level = '0;
        repeat (16) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_reset();
        t_flags();
        t_count();
        t_result();
        t_peak();
        final_report();
    end

    initial begin
        #100us;
        n_errors++;
        final_report();
    end
endmodule // testbench
